// ### ioc_pkg.sv
package ioc_pkg;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] CALIB_OFFSET = 12'h008;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DLY_EN_BIT = 2;
  localparam int CTRL_DLY_DYN_BIT = 3;
  localparam int CTRL_FIXED_LSB = 4;
  localparam int CTRL_XFER_EN_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // Status and calibration register fields.
  localparam int STATUS_LOCK_BIT = 6;
  localparam int STATUS_STREAM_A_BIT = 7;
  localparam int STATUS_STREAM_B_BIT = 8;
  localparam int STATUS_SDR_BIT = 9;
  localparam int CALIB_HALF1_LSB = 8;

  // Structure sizes and reset values.
  localparam int DELAY_SEL_W = 4;
  localparam int DELAY_TAPS = 15;
  localparam int CAL_CODE_W = 6;
  localparam int STROBE_LINE_DEPTH = 64;
  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;
  localparam logic DATA_RESET = 1'b0;

  // Input block operating modes.
  typedef enum logic [1:0] {
    MODE_BYPASS,
    MODE_SDR,
    MODE_DDR,
    MODE_GEARBOX
  } ioc_mode_e;

  // Device edge on which the cell sits.
  typedef enum logic [1:0] {
    EDGE_LEFT,
    EDGE_RIGHT,
    EDGE_BOTTOM,
    EDGE_TOP
  } ioc_edge_e;

endpackage

// Calibration loop: tracks the strobe period and yields a quarter-period
// delay code, one step per measured high phase.
`timescale 1ns/1ps
module ioc_cal_loop
  import ioc_pkg::*;
#(
  parameter int CODE_W = CAL_CODE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe_lvl,
  output logic [CODE_W-1:0] code,
  output logic locked
);

  logic lvl_prev_reg;
  logic [CODE_W:0] high_cnt_reg;
  logic [CODE_W-1:0] code_reg;
  logic locked_reg;
  logic [CODE_W-1:0] target;
  logic fall_seen;

  assign fall_seen = lvl_prev_reg && !strobe_lvl;
  // Half the high phase is a quarter of the strobe period.
  assign target = high_cnt_reg[CODE_W:1];
  assign code = code_reg;
  assign locked = locked_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_prev_reg <= 1'b0;
    end else begin
      lvl_prev_reg <= strobe_lvl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_reg <= '0;
    end else if (strobe_lvl && !lvl_prev_reg) begin
      high_cnt_reg <= (CODE_W+1)'(1);
    end else if (strobe_lvl && !(&high_cnt_reg)) begin
      high_cnt_reg <= high_cnt_reg + (CODE_W+1)'(1);
    end
  end

  // A single step per measurement keeps the code free of jumps.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= '0;
      locked_reg <= 1'b0;
    end else if (fall_seen) begin
      if (code_reg < target) begin
        code_reg <= code_reg + CODE_W'(1);
        locked_reg <= 1'b0;
      end else if (code_reg > target) begin
        code_reg <= code_reg - CODE_W'(1);
        locked_reg <= 1'b0;
      end else begin
        locked_reg <= 1'b1;
      end
    end
  end

  a_code_single_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    (code_reg != $past(code_reg)) |->
      (code_reg == $past(code_reg) + CODE_W'(1)) ||
      (code_reg == $past(code_reg) - CODE_W'(1))
  ) else $error("Calibration code moved by more than one step.");

endmodule

// ### ioc_input_capture.sv
`timescale 1ns/1ps
module ioc_input_capture
  import ioc_pkg::*;
#(
  parameter ioc_edge_e CELL_EDGE = EDGE_LEFT,
  parameter bit CELL_HALF = 1'b0,
  parameter bit SET_VALUE = 1'b0,
  parameter int DLY_TAPS = DELAY_TAPS,
  parameter int LINE_DEPTH = STROBE_LINE_DEPTH
) (
  // System clock and reset.
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  // Pad side: data, strobe clock and the strobe of the other half.
  input wire logic I_PAD_INPUT_DATA,
  input wire logic I_STROBE,
  input wire logic I_PEER_STROBE,
  // Core controls.
  input wire logic I_CE,
  input wire logic I_LOCAL_SET_RESET,
  input wire logic I_GLOBAL_SET_RESET_LOW,
  input wire logic [3:0] I_DYNAMIC_DELAY_SELECT,
  input wire logic I_DDR_CAPTURE_CLOCK_POLARITY,
  // Core data outputs.
  output logic O_UNREGISTERED_CORE_INPUT,
  output logic O_INPUT_TO_CLOCK_NET,
  output logic O_SDR_REGISTERED_INPUT,
  output logic O_DDR_INPUT_STREAM_A,
  output logic O_DDR_INPUT_STREAM_B,
  output logic O_GEARBOX_POS_INPUT_A,
  output logic O_GEARBOX_NEG_INPUT_A,
  // Strobe delay outputs.
  output logic O_STROBE_DELAY_UNIT_OUT,
  output logic O_OUTPUT_TRANSFER_STROBE,
  output logic O_CAL_LOCKED
);

  localparam bit GB_PRESENT = (CELL_EDGE != EDGE_TOP);

  logic [8:0] ctrl_reg;
  logic [31:0] prdata_reg;
  ioc_mode_e mode;
  logic dly_en, dly_dyn, xfer_en;
  logic [DELAY_SEL_W-1:0] fixed_sel, tap;
  logic [DLY_TAPS-1:0] dly_line_reg;
  logic [DLY_TAPS:0] dly_vec;
  logic delayed;
  logic [3:0] sync1_reg, sync2_reg;
  logic pad_s, strobe_s, peer_s, tgl_s;
  logic tgl_prev_reg, new_pair;
  logic rise_cap_reg, pair_rise_reg, pair_fall_reg, pair_tgl_reg;
  logic force_set;
  logic sdr_reg, stream_a_reg, stream_b_reg, gb_pos_reg, gb_neg_reg;
  logic [LINE_DEPTH-1:0] strobe_line_reg;
  logic strobe_dly_reg, xfer_reg;
  logic [CAL_CODE_W-1:0] cal_code [2];
  logic [1:0] cal_locked, cal_src;
  logic [CAL_CODE_W-1:0] own_code;
  logic apb_write, apb_setup_read, addr_hit;
  // Pad bypass paths carry no register at all.
  assign O_UNREGISTERED_CORE_INPUT = I_PAD_INPUT_DATA;
  assign O_INPUT_TO_CLOCK_NET = I_PAD_INPUT_DATA;
  assign mode = ioc_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign dly_en = ctrl_reg[CTRL_DLY_EN_BIT];
  assign dly_dyn = ctrl_reg[CTRL_DLY_DYN_BIT];
  assign xfer_en = ctrl_reg[CTRL_XFER_EN_BIT];
  assign fixed_sel = ctrl_reg[CTRL_FIXED_LSB +: DELAY_SEL_W];
  // APB slave with zero wait states; read data is loaded in setup.
  assign apb_write = I_PSEL && I_PENABLE && I_PWRITE;
  assign apb_setup_read = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign addr_hit = (I_PADDR == CTRL_OFFSET) ||
                    (I_PADDR == STATUS_OFFSET) ||
                    (I_PADDR == CALIB_OFFSET);
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_hit;
  assign O_PRDATA = prdata_reg;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_write && I_PADDR == CTRL_OFFSET) begin
      if (I_PSTRB[0]) begin
        ctrl_reg[7:0] <= I_PWDATA[7:0];
      end
      if (I_PSTRB[1]) begin
        ctrl_reg[8] <= I_PWDATA[8];
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      prdata_reg <= PRDATA_RESET;
    end else if (apb_setup_read) begin
      prdata_reg <= PRDATA_RESET;
      if (I_PADDR == CTRL_OFFSET) begin
        prdata_reg[8:0] <= ctrl_reg;
      end else if (I_PADDR == STATUS_OFFSET) begin
        prdata_reg[CAL_CODE_W-1:0] <= own_code;
        prdata_reg[STATUS_LOCK_BIT] <= cal_locked[CELL_HALF];
        prdata_reg[STATUS_STREAM_A_BIT] <= stream_a_reg;
        prdata_reg[STATUS_STREAM_B_BIT] <= stream_b_reg;
        prdata_reg[STATUS_SDR_BIT] <= sdr_reg;
      end else if (I_PADDR == CALIB_OFFSET) begin
        prdata_reg[CAL_CODE_W-1:0] <= cal_code[0];
        prdata_reg[CALIB_HALF1_LSB +: CAL_CODE_W] <= cal_code[1];
      end
    end
  end

  // Pad levels and the pair toggle each pass two flip-flops before use.
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {pair_tgl_reg, I_PEER_STROBE, I_STROBE, I_PAD_INPUT_DATA};
      sync2_reg <= sync1_reg;
    end
  end

  assign pad_s = sync2_reg[0];
  assign strobe_s = sync2_reg[1];
  assign peer_s = sync2_reg[2];
  assign tgl_s = sync2_reg[3];

  // Input delay line; tap zero is the undelayed sample.
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      dly_line_reg <= '0;
    end else begin
      dly_line_reg <= {dly_line_reg[DLY_TAPS-2:0], pad_s};
    end
  end

  assign dly_vec = {dly_line_reg, pad_s};

  always_comb begin
    tap = '0;
    if (dly_en && dly_dyn) begin
      tap = I_DYNAMIC_DELAY_SELECT;
    end else if (dly_en) begin
      tap = fixed_sel;
    end
  end

  assign delayed = dly_vec[tap];

  // Set/reset is synchronous so a glitch on routing cannot upset it.
  assign force_set = !I_GLOBAL_SET_RESET_LOW || I_LOCAL_SET_RESET;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sdr_reg <= DATA_RESET;
    end else if (force_set) begin
      sdr_reg <= SET_VALUE;
    end else if (I_CE && mode == MODE_SDR) begin
      sdr_reg <= delayed;
    end
  end

  assign O_SDR_REGISTERED_INPUT = sdr_reg;

  // Strobe domain. The strobe stops between bursts, so each pair is
  // completed on the falling edge that ends it and then handed over.
  always_ff @(posedge I_STROBE or negedge I_NRST) begin
    if (!I_NRST) begin
      rise_cap_reg <= DATA_RESET;
    end else begin
      rise_cap_reg <= I_PAD_INPUT_DATA;
    end
  end

  always_ff @(negedge I_STROBE or negedge I_NRST) begin
    if (!I_NRST) begin
      pair_rise_reg <= DATA_RESET;
      pair_fall_reg <= DATA_RESET;
      pair_tgl_reg <= 1'b0;
    end else begin
      pair_rise_reg <= rise_cap_reg;
      pair_fall_reg <= I_PAD_INPUT_DATA;
      pair_tgl_reg <= ~pair_tgl_reg;
    end
  end

  // The pair stays still for a whole strobe period, far longer than
  // the toggle takes to cross, so it is read without further sync.
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tgl_prev_reg <= 1'b0;
    end else begin
      tgl_prev_reg <= tgl_s;
    end
  end

  assign new_pair = tgl_s ^ tgl_prev_reg;

  // Strobe edge order and the polarity input choose which sample leads.
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      stream_a_reg <= DATA_RESET;
      stream_b_reg <= DATA_RESET;
    end else if (force_set) begin
      stream_a_reg <= SET_VALUE;
      stream_b_reg <= SET_VALUE;
    end else if (I_CE && new_pair && (mode == MODE_DDR ||
                 mode == MODE_GEARBOX)) begin
      if (I_DDR_CAPTURE_CLOCK_POLARITY) begin
        stream_a_reg <= pair_fall_reg;
        stream_b_reg <= pair_rise_reg;
      end else begin
        stream_a_reg <= pair_rise_reg;
        stream_b_reg <= pair_fall_reg;
      end
    end
  end

  assign O_DDR_INPUT_STREAM_A = stream_a_reg;
  assign O_DDR_INPUT_STREAM_B = stream_b_reg;

  // Gearbox keeps the previous pair, giving four streams per strobe; top-edge cells have none and tie both outputs low.
  generate
    if (GB_PRESENT) begin : g_gearbox
      always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
          gb_pos_reg <= DATA_RESET;
          gb_neg_reg <= DATA_RESET;
        end else if (force_set) begin
          gb_pos_reg <= SET_VALUE;
          gb_neg_reg <= SET_VALUE;
        end else if (I_CE && new_pair && mode == MODE_GEARBOX) begin
          gb_pos_reg <= stream_a_reg;
          gb_neg_reg <= stream_b_reg;
        end
      end
    end else begin : g_no_gearbox
      assign gb_pos_reg = DATA_RESET;
      assign gb_neg_reg = DATA_RESET;
    end
  endgenerate

  assign O_GEARBOX_POS_INPUT_A = gb_pos_reg;
  assign O_GEARBOX_NEG_INPUT_A = gb_neg_reg;

  // One calibration loop per device half.
  assign cal_src[CELL_HALF] = strobe_s;
  assign cal_src[!CELL_HALF] = peer_s;

  generate
    for (genvar h = 0; h < 2; h++) begin : g_cal
      ioc_cal_loop #(
        .CODE_W(CAL_CODE_W)
      ) u_cal (
        .clk(I_MCLK),
        .rst_n(I_NRST),
        .strobe_lvl(cal_src[h]),
        .code(cal_code[h]),
        .locked(cal_locked[h])
      );
    end
  endgenerate

  assign own_code = cal_code[CELL_HALF];
  assign O_CAL_LOCKED = cal_locked[CELL_HALF];

  // Strobe delay line tapped by the calibration code; the quarter
  // period tap gives the ninety-degree shifted strobe. Resolution is
  // one system clock, which limits how finely the shift can be placed.
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      strobe_line_reg <= '0;
      strobe_dly_reg <= 1'b0;
      xfer_reg <= 1'b0;
    end else begin
      strobe_line_reg <= {strobe_line_reg[LINE_DEPTH-2:0], strobe_s};
      strobe_dly_reg <= strobe_line_reg[own_code];
      xfer_reg <= xfer_en && strobe_line_reg[own_code];
    end
  end

  assign O_STROBE_DELAY_UNIT_OUT = strobe_dly_reg;
  assign O_OUTPUT_TRANSFER_STROBE = xfer_reg;
  a_bypass_paths: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    O_UNREGISTERED_CORE_INPUT == I_PAD_INPUT_DATA &&
      O_INPUT_TO_CLOCK_NET == I_PAD_INPUT_DATA
  ) else $error("Bypass path does not follow the pad.");
  a_delay_dynamic: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    (dly_en && dly_dyn && I_DYNAMIC_DELAY_SELECT == 4'h8) |->
      delayed == $past(pad_s, 8)
  ) else $error("Dynamic delay tap gives wrong age.");
  a_sdr_capture: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    (I_CE && !force_set && mode == MODE_SDR) |=>
      sdr_reg == $past(delayed)
  ) else $error("SDR register missed its sample.");
  a_ce_holds: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    (!I_CE && !force_set) |=> $stable(sdr_reg) && $stable(stream_a_reg)
  ) else $error("Register changed with enable low.");
  a_gsr_forces: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    !I_GLOBAL_SET_RESET_LOW |=> sdr_reg == SET_VALUE &&
      stream_b_reg == SET_VALUE
  ) else $error("Global set/reset did not force registers.");
  a_ddr_order: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    (I_CE && !force_set && new_pair && mode == MODE_DDR &&
      !I_DDR_CAPTURE_CLOCK_POLARITY) |=>
      stream_a_reg == $past(pair_rise_reg) &&
      stream_b_reg == $past(pair_fall_reg)
  ) else $error("DDR streams out of order.");
  a_ddr_polarity: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    (I_CE && !force_set && new_pair && mode == MODE_DDR &&
      I_DDR_CAPTURE_CLOCK_POLARITY) |=>
      stream_a_reg == $past(pair_fall_reg)
  ) else $error("Polarity input ignored.");
  a_gearbox_shift: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    (GB_PRESENT && I_CE && !force_set && new_pair &&
      mode == MODE_GEARBOX) |=> gb_pos_reg == $past(stream_a_reg)
  ) else $error("Gearbox did not keep the previous pair.");
  a_gearbox_top: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    !GB_PRESENT |-> !O_GEARBOX_POS_INPUT_A && !O_GEARBOX_NEG_INPUT_A
  ) else $error("Top-edge cell drives gearbox outputs.");
  a_xfer_tap: assert property (
    @(posedge I_MCLK) disable iff (!I_NRST)
    xfer_en |=> xfer_reg == $past(strobe_line_reg[own_code])
  ) else $error("Transfer strobe not at calibrated tap.");

endmodule

// ### ioc_ddr_source.sv
`timescale 1ns/1ps
module ioc_ddr_source (
  // Strobe and data toward the pad.
  output logic o_strobe,
  output logic o_data
);
  initial begin
    o_strobe = 1'b0;
    o_data = 1'b0;
  end

  // One strobe period carries two bits, centred on the edges. The strobe
  // stands still between frames, and once the hold time is over the data
  // line shows the inverse of its last bit, so a late sample cannot pass.
  task automatic send(input logic d0, input logic d1, input int half);
    #7;
    o_data = d0;
    #(half / 2);
    o_strobe = 1'b1;
    #(half / 2);
    o_data = d1;
    #(half / 2);
    o_strobe = 1'b0;
    #(half / 2);
    o_data = ~d1;
  endtask
endmodule

// ### ioc_input_capture_test.sv
`timescale 1ns/1ps
module ioc_input_capture_test;
  import ioc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic ce = 1'b1;
  logic local_set_reset = 1'b0;
  logic gsr_n = 1'b1;
  logic [3:0] dsel = 4'h0;
  logic pol = 1'b0;
  logic pad_sdr = 1'b0;
  logic use_src = 1'b0;
  logic [31:0] rdata;
  logic rerr;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int xfer_cnt = 0;
  int dly_cnt = 0;
  wire pready, pslverr, unreg, clknet, sdr, st_a, st_b, gb_p, gb_n;
  wire dly_out, xfer, locked, strobe, src_data, pad;
  wire [31:0] prdata;

  // The pad is fed by the source model during link traffic only.
  assign pad = use_src ? src_data : pad_sdr;

  always #5 clk = ~clk;

  ioc_ddr_source u_src (
    .o_strobe(strobe),
    .o_data(src_data)
  );

  ioc_input_capture dut (
    .I_MCLK(clk), .I_NRST(nrst),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
    .I_PAD_INPUT_DATA(pad), .I_STROBE(strobe), .I_PEER_STROBE(strobe),
    .I_CE(ce), .I_LOCAL_SET_RESET(local_set_reset), .I_GLOBAL_SET_RESET_LOW(gsr_n),
    .I_DYNAMIC_DELAY_SELECT(dsel), .I_DDR_CAPTURE_CLOCK_POLARITY(pol),
    .O_UNREGISTERED_CORE_INPUT(unreg), .O_INPUT_TO_CLOCK_NET(clknet),
    .O_SDR_REGISTERED_INPUT(sdr), .O_DDR_INPUT_STREAM_A(st_a),
    .O_DDR_INPUT_STREAM_B(st_b), .O_GEARBOX_POS_INPUT_A(gb_p),
    .O_GEARBOX_NEG_INPUT_A(gb_n), .O_STROBE_DELAY_UNIT_OUT(dly_out),
    .O_OUTPUT_TRANSFER_STROBE(xfer), .O_CAL_LOCKED(locked)
  );

  always @(posedge clk) begin
    cyc++;
    if (xfer === 1'b1) xfer_cnt++;
    if (dly_out === 1'b1) dly_cnt++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reg_test();
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl_reset", rdata, {23'h0, CTRL_RESET});
    apb(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl_rw", rdata, 32'h0000_01FF);
    apb(1'b1, 12'h00C, 32'h0);
    chk("bad_wr_err", rerr, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk("bad_rd_err", rerr, 1'b1);
    chk("bad_rd_data", rdata, 32'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl_kept", rdata, 32'h0000_01FF);
    chk("good_err", rerr, 1'b0);
    pstrb <= 4'h2;
    apb(1'b1, CTRL_OFFSET, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl_strb", rdata, 32'h0000_00FF);
  endtask

  task automatic bypass_test();
    apb(1'b1, CTRL_OFFSET, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pad_sdr <= i[0];
      @(negedge clk);
      chk("unreg", unreg, i[0]);
      chk("clknet", clknet, i[0]);
    end
  endtask

  // A delayed path must still show the old level early on and the new one
  // once the sync stages and the taps have passed.
  task automatic sdr_step(input logic [31:0] ctrl, input logic v,
                          input int early);
    apb(1'b1, CTRL_OFFSET, ctrl);
    @(posedge clk);
    pad_sdr <= v;
    if (early > 0) begin
      wait_cyc(early);
      chk("sdr_early", sdr, !v);
    end
    wait_cyc(20);
    chk("sdr_late", sdr, v);
  endtask

  task automatic sdr_test();
    sdr_step(32'h0000_0001, 1'b1, 0);
    sdr_step(32'h0000_0085, 1'b0, 6);
    @(posedge clk);
    dsel <= 4'h8;
    sdr_step(32'h0000_000D, 1'b1, 6);
    @(posedge clk);
    ce <= 1'b0;
    pad_sdr <= 1'b0;
    wait_cyc(25);
    chk("sdr_ce_hold", sdr, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    local_set_reset <= 1'b1;
    pad_sdr <= 1'b1;
    wait_cyc(3);
    chk("sdr_lsr", sdr, 1'b0);
    @(posedge clk);
    local_set_reset <= 1'b0;
  endtask

  task automatic ddr_pair(input logic d0, d1, input logic p);
    @(posedge clk);
    pol <= p;
    u_src.send(d0, d1, 32);
    wait_cyc(8);
    chk("stream_a", st_a, p ? d1 : d0);
    chk("stream_b", st_b, p ? d0 : d1);
  endtask

  task automatic ddr_test();
    use_src <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h0000_0002);
    for (int i = 0; i < 8; i++) ddr_pair(i[0], i[1], i[2]);
    ddr_pair(1'b1, 1'b1, 1'b0);
    chk("cal_locked", locked, 1'b1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status", rdata[8:0], 9'h1C1);
    apb(1'b0, CALIB_OFFSET, 32'h0);
    chk("calib", rdata, 32'h0000_0101);
    @(posedge clk);
    gsr_n <= 1'b0;
    wait_cyc(3);
    chk("gsr_a", st_a, 1'b0);
    chk("gsr_b", st_b, 1'b0);
    @(posedge clk);
    gsr_n <= 1'b1;
  endtask

  task automatic gearbox_test();
    apb(1'b1, CTRL_OFFSET, 32'h0000_0003);
    ddr_pair(1'b1, 1'b0, 1'b0);
    ddr_pair(1'b0, 1'b1, 1'b0);
    chk("gb_pos", gb_p, 1'b1);
    chk("gb_neg", gb_n, 1'b0);
    ddr_pair(1'b1, 1'b1, 1'b0);
    chk("gb_pos_2", gb_p, 1'b0);
    chk("gb_neg_2", gb_n, 1'b1);
  endtask

  task automatic strobe_test();
    int x0;
    int d0;
    apb(1'b1, CTRL_OFFSET, 32'h0000_0002);
    x0 = xfer_cnt;
    d0 = dly_cnt;
    ddr_pair(1'b1, 1'b0, 1'b0);
    chk("xfer_off", xfer_cnt == x0, 1'b1);
    chk("dly_moves", dly_cnt > d0, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0102);
    x0 = xfer_cnt;
    ddr_pair(1'b0, 1'b1, 1'b0);
    chk("xfer_on", xfer_cnt > x0, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    reg_test();
    bypass_test();
    sdr_test();
    ddr_test();
    gearbox_test();
    strobe_test();
    end_sim();
  end
endmodule
